/* core/ucsd_pkg.sv */
// Constants shared by the upper chip select decoder files
package ucsd_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam int UCSD_ADR_W = 34;
    localparam logic [31:0] UCSD_LOWER_IDX = 32'hfffff060;
    localparam logic [31:0] UCSD_UPPER_IDX = 32'hfffff062;
    localparam logic [31:0] UCSD_MODE_IDX = 32'hfffff06a;
    localparam logic [31:0] UCSD_STAT_IDX = 32'hfffff06c;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] UCSD_MAP_RST = 16'h2c11;
    localparam logic UCSD_MODE_RST = 1'b0;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int UCSD_MODE_BIT = 0;
    localparam int UCSD_STAT_PPIO_BIT = 8;
    localparam int UCSD_BANK_LSB = 22;
    localparam int UCSD_BANK_MSB = 25;
    localparam int UCSD_AREA_LSB = 26;
    localparam int UCSD_AREA_MSB = 27;
    localparam int UCSD_ACC_ADR_W = 28;

    // ------------------------------------------------------------
    // Areas decoded in 256 MB mode
    // ------------------------------------------------------------
    localparam logic [1:0] UCSD_AREA_SEL3 = 2'h0;
    localparam logic [1:0] UCSD_AREA_SEL1 = 2'h1;
    localparam logic [1:0] UCSD_AREA_SEL4 = 2'h2;
    localparam logic [1:0] UCSD_AREA_SEL6 = 2'h3;

endpackage

/* core/ucsd_prio.sv */
// Fixed priority picker: request 0 wins over all others
module ucsd_prio #(
    parameter int N = 4
) (
    input wire logic [N-1:0] req_i,
    output logic [N-1:0] grant_o
);
    logic [N-1:0] taken;

    assign taken[0] = 1'b0;

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_slot
            assign grant_o[i] = req_i[i] & ~taken[i];
            if (i < N - 1) begin : g_chain
                assign taken[i+1] = taken[i] | req_i[i];
            end
        end
    endgenerate
endmodule // ucsd_prio

/* core/ucsd_wb_regs.sv */
// Classic Wishbone slave holding the select maps and mode, reading back status
module ucsd_wb_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ucsd_pkg::UCSD_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [15:0] status_i,
    output logic [15:0] lower_map_o,
    output logic [15:0] upper_map_o,
    output logic mode_256_o
);
    import ucsd_pkg::*;

    logic ack_reg;
    logic [31:0] dat_reg;
    logic [15:0] lower_select_map_reg;
    logic [15:0] upper_select_map_reg;
    logic mode_reg;
    logic [31:0] idx;
    logic req;
    logic wr;
    logic [15:0] rd_next;

    assign idx = wb_adr_i[UCSD_ADR_W-1:2];
    assign req = wb_cyc_i & wb_stb_i;
    // Writes land on the edge where the master sees ack
    assign wr = req & wb_we_i & ack_reg;

    // ------------------------------------------------------------
    // Handshake: one wait state, ack dropped after one cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req & ~ack_reg;
        end
    end

    always_comb begin
        rd_next = 16'h0000;
        if (idx == UCSD_LOWER_IDX) begin
            rd_next = lower_select_map_reg;
        end else if (idx == UCSD_UPPER_IDX) begin
            rd_next = upper_select_map_reg;
        end else if (idx == UCSD_MODE_IDX) begin
            rd_next[UCSD_MODE_BIT] = mode_reg;
        end else if (idx == UCSD_STAT_IDX) begin
            rd_next = status_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= 32'h0000_0000;
        end else if (req & ~ack_reg) begin
            dat_reg <= {16'h0000, rd_next};
        end
    end

    // ------------------------------------------------------------
    // Storage, byte lanes 0 and 1 only
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lower_select_map_reg <= UCSD_MAP_RST;
            upper_select_map_reg <= UCSD_MAP_RST;
            mode_reg <= UCSD_MODE_RST;
        end else if (wr) begin
            if (idx == UCSD_LOWER_IDX) begin
                if (wb_sel_i[0]) lower_select_map_reg[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) lower_select_map_reg[15:8] <= wb_dat_i[15:8];
            end
            if (idx == UCSD_UPPER_IDX) begin
                if (wb_sel_i[0]) upper_select_map_reg[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) upper_select_map_reg[15:8] <= wb_dat_i[15:8];
            end
            if (idx == UCSD_MODE_IDX && wb_sel_i[0]) begin
                mode_reg <= wb_dat_i[UCSD_MODE_BIT];
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign lower_map_o = lower_select_map_reg;
    assign upper_map_o = upper_select_map_reg;
    assign mode_256_o = mode_reg;
endmodule // ucsd_wb_regs

/* core/ucsd_top.sv */
// Chip select decoder for selects 0 to 7 with Wishbone register access
//
// Function
// - Upper map register, reset 2c11, four fields
// - Select 4 enable bit 12: banks 12-15
// - Select 4 enable bit 13: banks 10-11
// - 256 MB mode: select 4 on area 2
// - Overlap: only higher priority select asserts
// - Select 2 beats lower ranks, banks 2-3
// - Select 1 beats select 3, banks 4-5
// - Upper order: 7, then 5, 6, 4
// - Peripheral I/O access forces all selects high
module ucsd_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ucsd_pkg::UCSD_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic acc_valid_i,
    input wire logic [ucsd_pkg::UCSD_ACC_ADR_W-1:0] acc_addr_i,
    input wire logic ppio_hit_i,
    output logic chip_sel_zero_n_o,
    output logic chip_sel_one_n_o,
    output logic chip_sel_two_n_o,
    output logic chip_sel_three_n_o,
    output logic chip_sel_four_n_o,
    output logic chip_sel_five_n_o,
    output logic chip_sel_six_n_o,
    output logic chip_sel_seven_n_o
);
    import ucsd_pkg::*;

    logic [15:0] lower_map;
    logic [15:0] upper_map;
    logic mode_256;
    logic [15:0] status;
    logic [3:0] bank;
    logic [1:0] area;
    logic [7:0] raw;
    logic [3:0] lo_grant;
    logic [3:0] hi_grant;
    logic [7:0] sel_next;
    logic [7:0] sel_reg;
    logic ppio_reg;
    logic sel4_banks_12_15_en;
    logic sel4_banks_10_11_en;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    ucsd_wb_regs u_regs (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .status_i(status),
        .lower_map_o(lower_map),
        .upper_map_o(upper_map),
        .mode_256_o(mode_256)
    );

    assign status = {7'h00, ppio_reg, sel_reg};

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    assign bank = acc_addr_i[UCSD_BANK_MSB:UCSD_BANK_LSB];
    assign area = acc_addr_i[UCSD_AREA_MSB:UCSD_AREA_LSB];
    assign sel4_banks_12_15_en = upper_map[12];
    assign sel4_banks_10_11_en = upper_map[13];

    // Raw requests, bit n stands for select n, before any priority
    always_comb begin
        raw = 8'h00;
        if (!mode_256) begin
            // Lower selects
            raw[0] = (bank < 4'h4) && lower_map[bank[1:0]];
            raw[1] = (lower_map[4] && bank <= 4'h1)
                || (lower_map[5] && (bank == 4'h2 || bank == 4'h3))
                || (lower_map[6] && bank == 4'h4)
                || (lower_map[7] && bank == 4'h5);
            raw[2] = (bank < 4'h4) && lower_map[{2'b10, bank[1:0]}];
            raw[3] = (lower_map[12] && bank < 4'h4)
                || (lower_map[13] && (bank == 4'h4 || bank == 4'h5))
                || (lower_map[14] && bank == 4'h6)
                || (lower_map[15] && bank == 4'h7);
            // Upper selects
            raw[4] = (sel4_banks_12_15_en && bank >= 4'hc)
                || (sel4_banks_10_11_en
                    && (bank == 4'ha || bank == 4'hb))
                || (upper_map[14] && bank == 4'h9)
                || (upper_map[15] && bank == 4'h8);
            raw[5] = (bank >= 4'hc)
                && upper_map[4'h8 + (4'hf - bank)];
            raw[6] = (upper_map[4] && bank >= 4'he)
                || (upper_map[5] && (bank == 4'hc || bank == 4'hd))
                || (upper_map[6] && bank == 4'hb)
                || (upper_map[7] && bank == 4'ha);
            raw[7] = (bank >= 4'hc)
                && upper_map[4'hf - bank];
        end else begin
            // Select 0 and 2 bank enables still apply inside area 0; select 3 takes area 0 whatever its enables hold
            raw[0] = (area == UCSD_AREA_SEL3) && (bank < 4'h4)
                && lower_map[bank[1:0]];
            raw[2] = (area == UCSD_AREA_SEL3) && (bank < 4'h4)
                && lower_map[{2'b10, bank[1:0]}];
            raw[1] = (area == UCSD_AREA_SEL1);
            raw[3] = (area == UCSD_AREA_SEL3);
            // Fixed areas, enable bits ignored
            raw[4] = (area == UCSD_AREA_SEL4);
            raw[6] = (area == UCSD_AREA_SEL6);
        end
    end

    // ------------------------------------------------------------
    // Priority within each group of four
    // ------------------------------------------------------------
    ucsd_prio #(.N(4)) u_lo_prio (
        .req_i({raw[3], raw[1], raw[2], raw[0]}),
        .grant_o(lo_grant)
    );

    ucsd_prio #(.N(4)) u_hi_prio (
        .req_i({raw[4], raw[6], raw[5], raw[7]}),
        .grant_o(hi_grant)
    );

    // A peripheral I/O hit overrides every bank decode
    always_comb begin
        sel_next = 8'h00;
        if (acc_valid_i && !ppio_hit_i) begin
            sel_next[0] = lo_grant[0];
            sel_next[2] = lo_grant[1];
            sel_next[1] = lo_grant[2];
            sel_next[3] = lo_grant[3];
            sel_next[7] = hi_grant[0];
            sel_next[5] = hi_grant[1];
            sel_next[6] = hi_grant[2];
            sel_next[4] = hi_grant[3];
        end
    end

    // ------------------------------------------------------------
    // Registered outputs: glitch free selects, one cycle latency
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_reg <= 8'h00;
        end else begin
            sel_reg <= sel_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ppio_reg <= 1'b0;
        end else if (acc_valid_i) begin
            ppio_reg <= ppio_hit_i;
        end
    end

    assign chip_sel_zero_n_o = ~sel_reg[0];
    assign chip_sel_one_n_o = ~sel_reg[1];
    assign chip_sel_two_n_o = ~sel_reg[2];
    assign chip_sel_three_n_o = ~sel_reg[3];
    assign chip_sel_four_n_o = ~sel_reg[4];
    assign chip_sel_five_n_o = ~sel_reg[5];
    assign chip_sel_six_n_o = ~sel_reg[6];
    assign chip_sel_seven_n_o = ~sel_reg[7];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic go64;
    logic [3:0] upper_low;
    assign go64 = acc_valid_i && !ppio_hit_i && !mode_256;
    assign upper_low = {chip_sel_seven_n_o, chip_sel_six_n_o,
                        chip_sel_five_n_o, chip_sel_four_n_o};
    logic [3:0] lower_low;
    assign lower_low = {chip_sel_three_n_o, chip_sel_two_n_o,
                        chip_sel_one_n_o, chip_sel_zero_n_o};

    a_upper_map_reset: assert property (
        $fell(rst_i) |-> upper_map == UCSD_MAP_RST && mode_256 == 1'b0
    ) else $error("upper map not at reset value after reset");

    a_sel4_high_banks: assert property (
        go64 && upper_map[12] && bank >= 4'hc
        |=> $countones(upper_low) == 3
    ) else $error("no upper select for enabled banks 12 to 15");

    a_sel4_mid_banks: assert property (
        go64 && upper_map[13] && !upper_map[6] && !upper_map[7]
            && (bank == 4'ha || bank == 4'hb)
        |=> !chip_sel_four_n_o && chip_sel_six_n_o
    ) else $error("select 4 missing for banks 10 or 11");

    a_sel4_area_two: assert property (
        acc_valid_i && !ppio_hit_i && mode_256 && area == UCSD_AREA_SEL4
        |=> !chip_sel_four_n_o && upper_low == 4'b1110
    ) else $error("select 4 missing on area 2 in 256 MB mode");

    a_sel0_wins_bank0: assert property (
        go64 && lower_map[0] && bank == 4'h0
        |=> !chip_sel_zero_n_o && chip_sel_one_n_o
            && chip_sel_two_n_o && chip_sel_three_n_o
    ) else $error("select 0 did not win bank 0");

    a_sel2_wins_bank23: assert property (
        go64 && bank[3:1] == 3'b001 && !lower_map[bank[1:0]]
            && lower_map[{2'b10, bank[1:0]}]
        |=> !chip_sel_two_n_o && chip_sel_one_n_o && chip_sel_three_n_o
    ) else $error("select 2 did not win bank 2 or 3");

    a_sel1_wins_bank45: assert property (
        go64 && ((bank == 4'h4 && lower_map[6])
            || (bank == 4'h5 && lower_map[7]))
        |=> !chip_sel_one_n_o && chip_sel_three_n_o
    ) else $error("select 1 did not win bank 4 or 5");

    a_upper_order: assert property (
        go64 && bank == 4'hf && upper_map[0] && upper_map[8]
        |=> !chip_sel_seven_n_o && chip_sel_five_n_o
            && chip_sel_six_n_o && chip_sel_four_n_o
    ) else $error("select 7 did not win over select 5");

    a_upper_one_hot: assert property (
        $countones(upper_low) >= 3
    ) else $error("two upper selects active together");

    a_ppio_all_high: assert property (
        acc_valid_i && ppio_hit_i
        |=> sel_reg == 8'h00 && ppio_reg
    ) else $error("select active during peripheral I/O access");

    a_sel5_bank15: assert property (
        go64 && bank == 4'hf && upper_map[8] && !upper_map[0]
        |=> !chip_sel_five_n_o
    ) else $error("select 5 missing for bank 15");

    a_lower_one_hot: assert property (
        $countones(lower_low) >= 3
    ) else $error("two lower selects active together");

    a_sel6_over_sel4: assert property (
        go64 && bank == 4'ha && upper_map[7]
        |=> !chip_sel_six_n_o && chip_sel_four_n_o
    ) else $error("select 6 did not win bank 10");

    a_sel5_over_sel6: assert property (
        go64 && bank == 4'hc && upper_map[11] && !upper_map[3]
        |=> !chip_sel_five_n_o && chip_sel_six_n_o
            && chip_sel_four_n_o
    ) else $error("select 5 did not win bank 12");

    a_sel4_low_banks: assert property (
        go64 && ((bank == 4'h9 && upper_map[14])
            || (bank == 4'h8 && upper_map[15]))
        |=> !chip_sel_four_n_o
    ) else $error("select 4 missing for bank 8 or 9");

    a_sel7_bank12: assert property (
        go64 && bank == 4'hc && upper_map[3]
        |=> !chip_sel_seven_n_o
    ) else $error("select 7 missing for bank 12");

    a_sel3_bank67: assert property (
        go64 && ((bank == 4'h6 && lower_map[14])
            || (bank == 4'h7 && lower_map[15]))
        |=> !chip_sel_three_n_o
    ) else $error("select 3 missing for bank 6 or 7");

    a_idle_all_high: assert property (
        !acc_valid_i |=> sel_reg == 8'h00
    ) else $error("select active without an access");

    a_sel6_area_three: assert property (
        acc_valid_i && !ppio_hit_i && mode_256 && area == UCSD_AREA_SEL6
        |=> !chip_sel_six_n_o && chip_sel_four_n_o
    ) else $error("select 6 missing on area 3 in 256 MB mode");

    c_sel4_area_two: cover property (
        mode_256 && !chip_sel_four_n_o
    );
    c_sel7_over_sel5: cover property (
        go64 && bank == 4'hf && upper_map[0] && upper_map[8]
        ##1 !chip_sel_seven_n_o
    );
    c_ppio_block: cover property (
        acc_valid_i && ppio_hit_i && raw != 8'h00
    );
    c_sel4_banks_10_11: cover property (
        go64 && upper_map[13] && bank == 4'ha ##1 !chip_sel_four_n_o
    );
    c_sel2_over_sel1: cover property (
        go64 && bank == 4'h2 && lower_map[5] && lower_map[10]
    );
endmodule // ucsd_top

/* verification/ucsd_ext_mem.sv */
// Model of the memories and peripherals that hang on the chip selects
module ucsd_ext_mem (
    input wire logic [7:0] sel_n_i,
    output logic [3:0] n_active_o,
    output logic [3:0] dev_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Each device answers only while its own select is low; two answering
    // at once would fight on the data bus, so the count is reported
    always_comb begin
        n_active_o = 4'h0;
        dev_o = 4'h8;
        for (int i = 0; i < 8; i++) begin
            if (sel_n_i[i] === 1'b0) begin
                n_active_o = n_active_o + 4'h1;
                dev_o = i[3:0];
            end
        end
    end
endmodule // ucsd_ext_mem

/* verification/ucsd_bench.sv */
// Self-checking testbench for the upper chip select decoder
module ucsd_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ucsd_pkg::*;
    // Bank masks: lower map bits 0-15, then upper map bits 0-15
    localparam logic [15:0] BANK_MASK [0:31] = '{
        16'h0001, 16'h0002, 16'h0004, 16'h0008,
        16'h0003, 16'h000c, 16'h0010, 16'h0020,
        16'h0001, 16'h0002, 16'h0004, 16'h0008,
        16'h000f, 16'h0030, 16'h0040, 16'h0080,
        16'h8000, 16'h4000, 16'h2000, 16'h1000,
        16'hc000, 16'h3000, 16'h0800, 16'h0400,
        16'h8000, 16'h4000, 16'h2000, 16'h1000,
        16'hf000, 16'h0c00, 16'h0200, 16'h0100};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [UCSD_ADR_W-1:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic acc_valid_i = 1'b0;
    logic [UCSD_ACC_ADR_W-1:0] acc_addr_i = '0;
    logic ppio_hit_i = 1'b0;
    logic [7:0] sel_n;
    logic [3:0] n_active;
    logic [3:0] dev;
    int n_errors = 0;
    int total_checks = 0;

    ucsd_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .acc_valid_i(acc_valid_i),
        .acc_addr_i(acc_addr_i), .ppio_hit_i(ppio_hit_i),
        .chip_sel_zero_n_o(sel_n[0]), .chip_sel_one_n_o(sel_n[1]),
        .chip_sel_two_n_o(sel_n[2]), .chip_sel_three_n_o(sel_n[3]),
        .chip_sel_four_n_o(sel_n[4]), .chip_sel_five_n_o(sel_n[5]),
        .chip_sel_six_n_o(sel_n[6]), .chip_sel_seven_n_o(sel_n[7]));
    ucsd_ext_mem mem_u (.sel_n_i(sel_n), .n_active_o(n_active),
        .dev_o(dev));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic results();
        $display("Checks %0d, errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wb_cycle(logic we, logic [31:0] idx, logic [15:0] d,
            logic [3:0] s, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {16'h0, d};
        wb_sel_i <= s;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            n_errors++;
            $display("Error at %0t: no acknowledge", $time);
            results();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(logic [31:0] idx, logic [15:0] d, logic [3:0] s = 4'h3);
        logic [31:0] q;
        wb_cycle(1'b1, idx, d, s, q);
    endtask

    task automatic rd(logic [31:0] idx, logic [31:0] exp);
        logic [31:0] q;
        wb_cycle(1'b0, idx, 16'h0, 4'h3, q);
        check(q, exp);
    endtask

    // Winning select for a bank, 8 when none; order 0,2,1,3 and 7,5,6,4
    function automatic int exp_sel(logic [15:0] lo, logic [15:0] up, int bank);
        int order [8] = '{0, 2, 1, 3, 7, 5, 6, 4};
        int s;
        int b;
        for (int k = 0; k < 8; k++) begin
            s = order[k];
            for (int j = 0; j < 4; j++) begin
                b = (s < 4) ? 4 * s + j : 4 * (7 - s) + j;
                if (s < 4 && lo[b] && BANK_MASK[b][bank]) return s;
                if (s >= 4 && up[b] && BANK_MASK[b + 16][bank]) return s;
            end
        end
        return 8;
    endfunction

    // One access, judged on the cycle after it is presented
    task automatic access(int area, int bank, logic ppio, int exp);
        logic [7:0] vec;
        @(posedge clk_i);
        acc_valid_i <= 1'b1;
        acc_addr_i <= {area[1:0], bank[3:0], 22'h0};
        ppio_hit_i <= ppio;
        @(posedge clk_i);
        #1;
        vec = (exp == 8) ? 8'hff : ~(8'h01 << exp);
        check({16'h0, n_active, dev, sel_n},
            {16'h0, (exp == 8) ? 4'h0 : 4'h1, exp[3:0], vec});
    endtask

    task automatic run_cfg(logic [15:0] lo, logic [15:0] up);
        wr(UCSD_LOWER_IDX, lo);
        wr(UCSD_UPPER_IDX, up);
        for (int b = 0; b < 16; b++) begin
            access(0, b, 1'b0, exp_sel(lo, up, b));
        end
    endtask

    task automatic test_regs();
        rd(UCSD_UPPER_IDX, 32'h0000_2c11);
        rd(UCSD_LOWER_IDX, 32'h0000_2c11);
        rd(UCSD_MODE_IDX, 32'h0);
        for (int b = 0; b < 16; b++) begin
            access(0, b, 1'b0, exp_sel(16'h2c11, 16'h2c11, b));
        end
        wr(UCSD_UPPER_IDX, 16'h0000);
        wr(UCSD_UPPER_IDX, 16'hffff, 4'h1);
        rd(UCSD_UPPER_IDX, 32'h0000_00ff);
        wr(32'hfffff070, 16'h1234);
        rd(32'hfffff070, 32'h0);
    endtask

    task automatic test_decode_64();
        logic [15:0] pairs [0:15] = '{16'h1111, 16'h0000, 16'h1f20, 16'h0000,
            16'h20c0, 16'h0000, 16'hffff, 16'hffff, 16'h0000, 16'h0ff0,
            16'h0000, 16'hf0f0, 16'h0000, 16'hf00f, 16'h2c11, 16'h2c11};
        for (int i = 0; i < 32; i++) begin
            run_cfg((i < 16) ? 16'h1 << i : 16'h0,
                (i < 16) ? 16'h0 : 16'h1 << (i - 16));
        end
        for (int i = 0; i < 16; i += 2) begin
            run_cfg(pairs[i], pairs[i + 1]);
        end
    endtask

    // Area 2 follows select 4 whatever its enables hold
    task automatic test_mode_256();
        wr(UCSD_MODE_IDX, 16'h0001);
        rd(UCSD_MODE_IDX, 32'h1);
        for (int u = 0; u < 2; u++) begin
            wr(UCSD_UPPER_IDX, (u == 0) ? 16'h0000 : 16'hffff);
            for (int b = 0; b < 16; b++) begin
                access(2, b, 1'b0, 4);
            end
        end
        // Fixed areas of the other selects; lower map still 2c11 here
        access(3, 0, 1'b0, 6);
        access(1, 9, 1'b0, 1);
        access(0, 7, 1'b0, 3);
        access(0, 2, 1'b0, 2);
        wr(UCSD_MODE_IDX, 16'h0000);
    endtask

    task automatic test_ppio();
        wr(UCSD_LOWER_IDX, 16'hffff);
        wr(UCSD_UPPER_IDX, 16'hffff);
        access(0, 12, 1'b1, 8);
        access(0, 0, 1'b1, 8);
        @(posedge clk_i);
        acc_valid_i <= 1'b0;
        ppio_hit_i <= 1'b0;
        rd(UCSD_STAT_IDX, 32'h0000_0100);
        access(0, 12, 1'b0, 7);
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        check({24'h0, sel_n}, 32'h0000_00ff);
        test_regs();
        test_decode_64();
        test_mode_256();
        test_ppio();
        results();
    end
endmodule // ucsd_bench
